//--- core/bimo_regs.svh
/*
 * Constants of the branch/increment/move execution block: register offsets,
 * field positions, reset values and instruction encodings.
 * Assumes it is included by its bare name wherever these values are needed.
 */
`ifndef BIMO_REGS_SVH
`define BIMO_REGS_SVH

// register offsets (byte addresses, one aligned word each)
`define BIMO_OFF_CTRL 8'h00
`define BIMO_OFF_STATE 8'h04
`define BIMO_OFF_WORK 8'h08
`define BIMO_OFF_OPTION 8'h0C
`define BIMO_OFF_STATUS 8'h10
`define BIMO_OFF_STACK 8'h14
`define BIMO_OFF_FILEPTR 8'h18
`define BIMO_OFF_FILEDATA 8'h1C

// field positions
`define BIMO_CTRL_RUN_BIT 0
`define BIMO_STATE_VALID_BIT 16
`define BIMO_STATE_STAT_LSB 24
`define BIMO_Z_BIT 2
`define BIMO_PAGE_MSB 6
`define BIMO_PAGE_LSB 5

// reset values
`define BIMO_RESET_PC 11'h7FF
`define BIMO_WORK_RST 8'h00
`define BIMO_STATUS_RST 8'h00
`define BIMO_OPTION_RST 8'hFF

// instruction encodings
`define BIMO_ENC_JUMP 3'h5
`define BIMO_ENC_RETURN 4'h8
`define BIMO_ENC_INC 6'h0A
`define BIMO_ENC_INCSKIP 6'h0F
`define BIMO_ENC_COPY_WORK 7'h01
`define BIMO_ENC_OPTION 12'h002

// bus responses
`define BIMO_RESP_OKAY 2'h0
`define BIMO_RESP_SLVERR 2'h2

`endif

//--- core/bimo_pkg.sv
/*
 * Types of the branch/increment/move execution block: instruction word,
 * operation kinds and the decoded instruction, with the decoder itself.
 * Assumes bimo_regs.svh is on the include path.
 */
`include "bimo_regs.svh"

package bimo_pkg;

	typedef logic [11:0] bimoWord_t;

	// operation kinds of the implemented subset
	typedef enum logic [2:0] {
		OP_NOP = 3'b000,
		OP_JUMP = 3'b001,
		OP_INC = 3'b010,
		OP_INCSKIP = 3'b011,
		OP_COPY_WORK = 3'b100,
		OP_OPTION = 3'b101,
		OP_RETURN = 3'b110
	} bimoOp_t;

	typedef struct packed {
		bimoOp_t op;
		logic dest;
		logic [4:0] fileAddr;
		logic [8:0] lit;
	} bimoDec_t;

	// words outside the subset decode as no-operation
	function automatic bimoDec_t bimoDecode(input bimoWord_t w);
		bimoDec_t d;
		d.dest = w[5];
		d.fileAddr = w[4:0];
		d.lit = w[8:0];
		if (w[11:9] == `BIMO_ENC_JUMP) begin
			d.op = OP_JUMP;
		end else if (w[11:8] == `BIMO_ENC_RETURN) begin
			d.op = OP_RETURN;
		end else if (w[11:6] == `BIMO_ENC_INC) begin
			d.op = OP_INC;
		end else if (w[11:6] == `BIMO_ENC_INCSKIP) begin
			d.op = OP_INCSKIP;
		end else if (w[11:5] == `BIMO_ENC_COPY_WORK) begin
			d.op = OP_COPY_WORK;
		end else if (w == `BIMO_ENC_OPTION) begin
			d.op = OP_OPTION;
		end else begin
			d.op = OP_NOP;
		end
		return d;
	endfunction : bimoDecode

endpackage : bimo_pkg

//--- core/bimo_core.sv
/*
 * Execution core for jump, increment, increment-with-skip, work-to-file move,
 * option load, no-operation and return-with-constant, with its own work,
 * status, option and file registers, a small return stack, and an AXI4-Lite
 * slave for control and inspection.
 * Assumes program memory answers progWord combinationally for progAddr.
 */
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "bimo_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// (RULE1) jump loads nine-bit immediate into low PC
// (RULE2) jump fills upper PC from status page bits
// (RULE3) jump takes two cycles, flags untouched
// (RULE4) add one to file sets zero flag
// (RULE5) dest bit: 0 to work, 1 to file
// (RULE6) skip variant keeps flags, squashes fetched word on zero result
// (RULE7) skip variant: one cycle, two on skip
// (RULE8) copy work to file, one cycle, no flags
// (RULE9) option word loads option from work
// (RULE10) return puts eight-bit constant in work
// (RULE11) return reloads PC from stack top, two cycles
// (RULE12) all-zero word changes nothing, one cycle
// (RULE13) PC beyond memory wraps to low addresses
// (RULE14) two-cycle ops flush prefetched word first
module bimo_core #(
	parameter int PROG_AW = 9,
	parameter int STACK_D = 2,
	parameter int FILE_N = 32,
	parameter int AXI_AW = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// program memory fetch
	output logic [PROG_AW-1:0] progAddr,
	input wire bimo_pkg::bimoWord_t progWord,
	// option register toward the timer
	output logic [7:0] optionOut,
	// AXI4-Lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [AXI_AW-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [AXI_AW-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	import bimo_pkg::*;

	localparam logic [10:0] RESET_PC_FULL = `BIMO_RESET_PC;

	// fetch and execute state
	logic [PROG_AW-1:0] pcFetch_r;
	bimoWord_t instr_r;
	logic execValid_r;
	// architectural state
	logic [7:0] wReg_r;
	logic [7:0] statusReg_r;
	logic [7:0] optionReg_r;
	logic [7:0] fileMem_r [FILE_N];
	logic [PROG_AW-1:0] stack_r [STACK_D];
	// control
	logic runCtrl_r;
	logic [4:0] filePtr_r;
	// bus slave
	logic awready_r;
	logic wready_r;
	logic awHeld_r;
	logic wHeld_r;
	logic [AXI_AW-1:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// decode and datapath
	bimoDec_t dec;
	logic [7:0] incResult;
	logic incZero;
	logic flush;
	logic [10:0] jumpFull;
	logic busWrEn;
	logic busWrLane0;
	logic coreWrOk;
	logic [31:0] rdMux;
	logic rdErr;
	logic wrErr;

	// register hit on the word address; upper address bits must be zero
	function automatic logic regHit(input logic [AXI_AW-1:0] addr, input logic [7:0] off);
		return ((addr >> 8) == '0) && (addr[7:2] == off[7:2]);
	endfunction : regHit

	function automatic logic isMapped(input logic [AXI_AW-1:0] addr);
		return regHit(addr, `BIMO_OFF_CTRL) || regHit(addr, `BIMO_OFF_STATE)
			|| regHit(addr, `BIMO_OFF_WORK) || regHit(addr, `BIMO_OFF_OPTION)
			|| regHit(addr, `BIMO_OFF_STATUS) || regHit(addr, `BIMO_OFF_STACK)
			|| regHit(addr, `BIMO_OFF_FILEPTR) || regHit(addr, `BIMO_OFF_FILEDATA);
	endfunction : isMapped

	////////////////////////////////////////////////////////////////////////////
	// datapath of the instruction in execute
	always_comb begin
		dec = bimoDecode(instr_r);
		incResult = fileMem_r[dec.fileAddr] + 8'h01;
		incZero = (incResult == 8'h00);
		jumpFull = {statusReg_r[`BIMO_PAGE_MSB:`BIMO_PAGE_LSB], dec.lit}; // RULE2
		flush = 1'b0;
		if (execValid_r) begin
			flush = (dec.op == OP_JUMP) || (dec.op == OP_RETURN) // RULE3 RULE11
				|| ((dec.op == OP_INCSKIP) && incZero); // RULE6 RULE7
		end
	end

	// a write commits once address and data are both held
	assign busWrEn = awHeld_r && wHeld_r && !bvalid_r;
	assign busWrLane0 = busWrEn && wStrb_r[0];
	// core state only takes bus writes while halted, so the two never collide
	assign coreWrOk = busWrLane0 && !runCtrl_r;
	assign wrErr = !isMapped(awAddr_r);

	////////////////////////////////////////////////////////////////////////////
	// fetch: the next word is prefetched while the current one executes
	always_ff @(posedge clk) begin
		if (rst) begin
			pcFetch_r <= RESET_PC_FULL[PROG_AW-1:0]; // RULE13
			instr_r <= 12'h000;
			execValid_r <= 1'b0;
		end else if (runCtrl_r) begin
			instr_r <= progWord;
			if (flush) begin
				execValid_r <= 1'b0; // RULE14
			end else begin
				execValid_r <= 1'b1;
			end
			if (execValid_r && dec.op == OP_JUMP) begin
				pcFetch_r <= jumpFull[PROG_AW-1:0]; // RULE1 RULE13
			end else if (execValid_r && dec.op == OP_RETURN) begin
				pcFetch_r <= stack_r[0]; // RULE11
			end else begin
				pcFetch_r <= pcFetch_r + 1'b1; // RULE13
			end
		end
	end

	assign progAddr = pcFetch_r;

	////////////////////////////////////////////////////////////////////////////
	// architectural state: executed by the core, or written by the bus when halted
	always_ff @(posedge clk) begin
		if (rst) begin
			wReg_r <= `BIMO_WORK_RST;
			statusReg_r <= `BIMO_STATUS_RST;
			optionReg_r <= `BIMO_OPTION_RST;
			for (int i = 0; i < FILE_N; i++) begin
				fileMem_r[i] <= 8'h00;
			end
			for (int i = 0; i < STACK_D; i++) begin
				stack_r[i] <= '0;
			end
		end else if (runCtrl_r && execValid_r) begin
			case (dec.op)
				OP_INC: begin
					if (dec.dest) begin
						fileMem_r[dec.fileAddr] <= incResult; // RULE4 RULE5
					end else begin
						wReg_r <= incResult; // RULE5
					end
					statusReg_r[`BIMO_Z_BIT] <= incZero; // RULE4
				end
				OP_INCSKIP: begin
					// flags stay as they are here
					if (dec.dest) begin
						fileMem_r[dec.fileAddr] <= incResult; // RULE5 RULE6
					end else begin
						wReg_r <= incResult; // RULE5 RULE6
					end
				end
				OP_COPY_WORK: begin
					fileMem_r[dec.fileAddr] <= wReg_r; // RULE8
				end
				OP_OPTION: begin
					optionReg_r <= wReg_r; // RULE9
				end
				OP_RETURN: begin
					wReg_r <= dec.lit[7:0]; // RULE10
					// pop; the bottom entry keeps its value
					for (int i = 0; i < STACK_D - 1; i++) begin
						stack_r[i] <= stack_r[i+1]; // RULE11
					end
				end
				default: begin
					// jump and no-operation touch no state here
				end // RULE3 RULE12
			endcase
		end else if (coreWrOk) begin
			if (regHit(awAddr_r, `BIMO_OFF_WORK)) begin
				wReg_r <= wData_r[7:0];
			end else if (regHit(awAddr_r, `BIMO_OFF_STATUS)) begin
				statusReg_r <= wData_r[7:0];
			end else if (regHit(awAddr_r, `BIMO_OFF_FILEDATA)) begin
				fileMem_r[filePtr_r] <= wData_r[7:0];
			end else if (regHit(awAddr_r, `BIMO_OFF_STACK)) begin
				// push: new return address on top
				stack_r[0] <= wData_r[PROG_AW-1:0];
				for (int i = 1; i < STACK_D; i++) begin
					stack_r[i] <= stack_r[i-1];
				end
			end
		end
	end

	assign optionOut = optionReg_r;

	////////////////////////////////////////////////////////////////////////////
	// control register and file pointer, bus only
	always_ff @(posedge clk) begin
		if (rst) begin
			runCtrl_r <= 1'b0;
			filePtr_r <= 5'h00;
		end else if (busWrLane0) begin
			if (regHit(awAddr_r, `BIMO_OFF_CTRL)) begin
				runCtrl_r <= wData_r[`BIMO_CTRL_RUN_BIT];
			end else if (regHit(awAddr_r, `BIMO_OFF_FILEPTR)) begin
				filePtr_r <= wData_r[4:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write channels: address and data are held independently, either order
	always_ff @(posedge clk) begin
		if (rst) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `BIMO_RESP_OKAY;
		end else begin
			// ready reopens only when the previous write has fully retired
			if (!awHeld_r && !bvalid_r && !awready_r) begin
				awready_r <= 1'b1;
			end
			if (!wHeld_r && !bvalid_r && !wready_r) begin
				wready_r <= 1'b1;
			end
			if (awvalid && awready_r) begin
				awHeld_r <= 1'b1;
				awAddr_r <= awaddr;
				awready_r <= 1'b0;
			end
			if (wvalid && wready_r) begin
				wHeld_r <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
				wready_r <= 1'b0;
			end
			if (busWrEn) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wrErr ? `BIMO_RESP_SLVERR : `BIMO_RESP_OKAY;
			end
			if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	////////////////////////////////////////////////////////////////////////////
	// read mux: shows live core state
	always_comb begin
		rdMux = 32'h00000000;
		rdErr = 1'b0;
		if (regHit(araddr, `BIMO_OFF_CTRL)) begin
			rdMux[`BIMO_CTRL_RUN_BIT] = runCtrl_r;
		end else if (regHit(araddr, `BIMO_OFF_STATE)) begin
			rdMux[PROG_AW-1:0] = pcFetch_r;
			rdMux[`BIMO_STATE_VALID_BIT] = execValid_r;
			rdMux[`BIMO_STATE_STAT_LSB +: 8] = statusReg_r;
		end else if (regHit(araddr, `BIMO_OFF_WORK)) begin
			rdMux[7:0] = wReg_r;
		end else if (regHit(araddr, `BIMO_OFF_OPTION)) begin
			rdMux[7:0] = optionReg_r;
		end else if (regHit(araddr, `BIMO_OFF_STATUS)) begin
			rdMux[7:0] = statusReg_r;
		end else if (regHit(araddr, `BIMO_OFF_STACK)) begin
			rdMux[PROG_AW-1:0] = stack_r[0];
		end else if (regHit(araddr, `BIMO_OFF_FILEPTR)) begin
			rdMux[4:0] = filePtr_r;
		end else if (regHit(araddr, `BIMO_OFF_FILEDATA)) begin
			rdMux[7:0] = fileMem_r[filePtr_r];
		end else begin
			rdErr = 1'b1;
		end
	end

	// read channel: one read in flight, data captured at the address edge
	always_ff @(posedge clk) begin
		if (rst) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `BIMO_RESP_OKAY;
		end else begin
			if (!rvalid_r && !arready_r) begin
				arready_r <= 1'b1;
			end
			if (arvalid && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= rdMux;
				rresp_r <= rdErr ? `BIMO_RESP_SLVERR : `BIMO_RESP_OKAY;
			end
			if (rvalid_r && rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

endmodule : bimo_core

//--- testbench/bimo_core_checker.sv
/* bimo_core_checker: fetch-order and bus-timing assertions on bimo_core ports.
   assumes one clock domain and a synchronous active-high rst. */
`timescale 1ns/1ps
module bimo_core_checker #(
	parameter int PROG_AW = 9
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fetch port
	input wire logic [PROG_AW-1:0] progAddr,
	input wire bimo_pkg::bimoWord_t progWord,
	// write channels
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	// read channels
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [7:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	import bimo_pkg::*;
	bimoWord_t w1;
	bimoWord_t w2;
	logic w2Flow;
	////////////////////////////////
	// w2 holds the word executed one cycle ago; needs two running edges to be meaningful
	always_ff @(posedge clk) begin
		w1 <= progWord;
		w2 <= w1;
		// the word before may have squashed w2: jump, return or skip variant
		w2Flow <= (w2[11:9] == 3'h5) || (w2[11:8] == 4'h8) || (w2[11:6] == 6'h0F);
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	a_jump_target: assert property (
		$changed(progAddr) ##1 ($changed(progAddr) && w2[11:9] == 3'h5 && !w2Flow)
		|-> progAddr[8:0] == w2[8:0]) else $error("jump target wrong");
	a_step_next: assert property (
		$changed(progAddr) ##1 ($changed(progAddr) && w2[11:9] != 3'h5 && w2[11:8] != 4'h8)
		|-> progAddr == $past(progAddr) + 1'h1) else $error("fetch not sequential");
	a_return_flush: assert property (
		$changed(progAddr) ##1 ($changed(progAddr) && w2[11:8] == 4'h8)
		|=> $stable(progAddr) || progAddr == $past(progAddr) + 1'h1) else $error("no dead slot");
	a_read_answer: assert property (
		arvalid && arready |=> rvalid) else $error("read answer late");
	a_bad_read: assert property (
		arvalid && arready && araddr > 8'h1F |=> rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read accepted");
	a_write_answer: assert property (
		awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write answer late");
	a_write_again: assert property (
		bvalid && bready |-> ##2 awready && wready) else $error("write ready not back");
	a_read_again: assert property (
		rvalid && rready |-> ##2 arready) else $error("read ready not back");
endmodule : bimo_core_checker
bind bimo_core bimo_core_checker #(.PROG_AW(PROG_AW)) u_chk (.clk(clk), .rst(rst),
	.progAddr(progAddr), .progWord(progWord), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.rresp(rresp));

//--- testbench/bimo_prog_mem.sv
/* bimo_prog_mem: program memory model, one 12-bit word per address.
   assumes the core fetches combinationally; unloaded words read as no-op. */
`timescale 1ns/1ps
module bimo_prog_mem #(
	parameter int AW = 11
) (
	// fetch port
	input wire logic [AW-1:0] progAddr,
	output bimo_pkg::bimoWord_t progWord
);
	import bimo_pkg::*;
	bimoWord_t rom [2**AW];
	// zero fill, so stray fetches run as no-op
	initial begin
		foreach (rom[i]) begin
			rom[i] = 12'h000;
		end
	end
	// answer in the same cycle as the address
	assign progWord = rom[progAddr];
endmodule : bimo_prog_mem

//--- testbench/bimo_core_tb.sv
/* bimo_core_tb: register map checks, then one program run on bimo_core.
   assumes bimo_prog_mem as program memory and the checker bound in. */
`timescale 1ns/1ps
`include "bimo_regs.svh"
module bimo_core_tb;
	import bimo_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [7:0] optionOut;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	logic [10:0] progAddr;
	bimoWord_t progWord;
	int badCount = 0;
	int cmpCount = 0;
	int cyc = 0;
	// eleven address bits so page bits reach the fetch address
	bimo_core #(.PROG_AW(11)) dut (.clk(clk), .rst(rst), .progAddr(progAddr),
		.progWord(progWord), .optionOut(optionOut), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));
	bimo_prog_mem mem (.progAddr(progAddr), .progWord(progWord));
	////////////////////////////////
	// 200 MHz clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	// a hang ends the run as a failure
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			badCount++;
			stopTest();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			badCount++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// write with address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do begin
			@(posedge clk);
			awvalid <= awvalid && !awready;
			wvalid <= wvalid && !wready;
		end while ((awvalid && !awready) || (wvalid && !wready));
		bready <= 1'h1;
		do @(posedge clk); while (!bvalid);
		bready <= 1'h0;
		chk(32'(bresp), 32'(e));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(posedge clk); while (!rvalid);
		rready <= 1'h0;
		chk(rdata, e);
		chk(32'(rresp), 32'(r));
	endtask : rd
	task automatic fput(input logic [7:0] i, input logic [7:0] v);
		wr(`BIMO_OFF_FILEPTR, 32'(i), 2'h0);
		wr(`BIMO_OFF_FILEDATA, 32'(v), 2'h0);
	endtask : fput
	// the fetch address may show for one cycle only, so poll every edge
	task automatic wait_pc(input logic [10:0] a);
		int n;
		n = 0;
		while (progAddr !== a && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(32'(progAddr), 32'(a));
	endtask : wait_pc
	task automatic check_regs;
		chk(32'(optionOut), 32'hFF);
		rd(`BIMO_OFF_WORK, 32'h0, 2'h0);
		rd(8'h40, 32'h0, 2'h2);
		wr(8'h40, 32'h1, 2'h2);
		wr(`BIMO_OFF_OPTION, 32'h12, 2'h0);
		rd(`BIMO_OFF_OPTION, 32'hFF, 2'h0);
	endtask : check_regs
	// squashed slots hold stores whose files must keep their values
	task automatic run_program;
		bimoWord_t p [12];
		logic [7:0] fi [9];
		logic [7:0] fe [9];
		p = '{12'h027, 12'h002, 12'h284, 12'h02B, 12'h2A3, 12'h3C4, 12'h3E5, 12'h2A6,
			12'h3C6, 12'h02A, 12'hA10, 12'h028};
		fi = '{8'h07, 8'h0B, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h08, 8'h09};
		fe = '{8'h4F, 8'h11, 8'h00, 8'h10, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
		for (int k = 0; k < 12; k++) begin
			mem.rom[k] = p[k];
		end
		mem.rom[11'h610] = 12'h85A;
		mem.rom[11'h611] = 12'h029;
		mem.rom[11'h720] = 12'hB20;
		wr(`BIMO_OFF_WORK, 32'h4F, 2'h0);
		wr(`BIMO_OFF_STATUS, 32'h60, 2'h0);
		wr(`BIMO_OFF_STACK, 32'h720, 2'h0);
		fput(8'h03, 8'hFF);
		fput(8'h04, 8'h10);
		fput(8'h05, 8'hFF);
		fput(8'h06, 8'h01);
		wr(`BIMO_OFF_CTRL, 32'h1, 2'h0);
		wait_pc(11'h610);
		wait_pc(11'h720);
		wr(`BIMO_OFF_WORK, 32'h33, 2'h0);
		wr(`BIMO_OFF_CTRL, 32'h0, 2'h0);
		chk(32'(optionOut), 32'h4F);
		rd(`BIMO_OFF_WORK, 32'h5A, 2'h0);
		rd(`BIMO_OFF_STATUS, 32'h64, 2'h0);
		rd(`BIMO_OFF_STACK, 32'h0, 2'h0);
		for (int k = 0; k < 9; k++) begin
			wr(`BIMO_OFF_FILEPTR, 32'(fi[k]), 2'h0);
			rd(`BIMO_OFF_FILEDATA, 32'(fe[k]), 2'h0);
		end
	endtask : run_program
	task automatic stopTest;
		$display("Checks %0d, errors %0d", cmpCount, badCount);
		if (badCount == 0 && cmpCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stopTest
	// reset for ten cycles, then the scenarios
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		check_regs();
		run_program();
		stopTest();
	end
endmodule : bimo_core_tb
